// ---- rtl/bqm_top.v ----
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`include "bqm_map.vh"
module bqm_top (
  input wire CLK_I,
  input wire RST_I,
  input wire [`BQM_AW-1:0] AWADDR_I,
  input wire AWVALID_I,
  output wire AWREADY_O,
  input wire [31:0] WDATA_I,
  input wire [3:0] WSTRB_I,
  input wire WVALID_I,
  output wire WREADY_O,
  output wire [1:0] BRESP_O,
  output wire BVALID_O,
  input wire BREADY_I,
  input wire [`BQM_AW-1:0] ARADDR_I,
  input wire ARVALID_I,
  output wire ARREADY_O,
  output wire [31:0] RDATA_O,
  output wire [1:0] RRESP_O,
  output wire RVALID_O,
  input wire RREADY_I,
  output wire [127:0] FLAG_BUS_O,
  output wire LOWER_GROUP_IRQ_O,
  output wire UPPER_GROUP_IRQ_O
);
  localparam R_QDATA = 3'h0;
  localparam R_QCFG = 3'h1;
  localparam R_QSTAT = 3'h2;
  localparam R_ILO = 3'h3;
  localparam R_IHI = 3'h4;
  localparam R_SRAM = 3'h5;
  localparam R_NONE = 3'h7;

  function [2:0] region;
    input [`BQM_AW-1:0] a;
    begin
      if (a >= `BQM_OFF_SRAM)
        region = R_SRAM;
      else if (a < `BQM_OFF_QDATA + 14'h0100)
        region = R_QDATA;
      else if (a[13:8] == `BQM_OFF_QCFG >> 8)
        region = R_QCFG;
      else if (a[13:8] == `BQM_OFF_QSTAT >> 8)
        region = R_QSTAT;
      else if (a == `BQM_OFF_ILO)
        region = R_ILO;
      else if (a == `BQM_OFF_IHI)
        region = R_IHI;
      else
        region = R_NONE;
    end
  endfunction

  function [6:0] ptr_mask;
    input [1:0] s;
    begin
      case (s)
        2'h0: ptr_mask = 7'h0F;
        2'h1: ptr_mask = 7'h1F;
        2'h2: ptr_mask = 7'h3F;
        default: ptr_mask = 7'h7F;
      endcase
    end
  endfunction

  function [1:0] last_sub;
    input [1:0] e;
    begin
      case (e)
        2'h0: last_sub = 2'h0;
        2'h1: last_sub = 2'h1;
        default: last_sub = 2'h3;
      endcase
    end
  endfunction

  reg [31:0] mem_q [0:2047];
  reg [24:0] cfg_q [0:`BQM_NQ-1];
  reg [6:0] wptr_q [0:`BQM_NQ-1];
  reg [6:0] rptr_q [0:`BQM_NQ-1];
  reg [1:0] wsub_q [0:`BQM_NQ-1];
  reg [1:0] rsub_q [0:`BQM_NQ-1];
  reg [7:0] cnt_q [0:`BQM_NQ-1];
  reg [63:0] unf_q;
  reg [63:0] ovf_q;
  reg [255:0] flg_q;
  reg [255:0] flg_p_q;
  reg [31:0] ist_lo_q;
  reg [31:0] ist_hi_q;
  reg irq_lo_q;
  reg irq_hi_q;
  reg awready_q;
  reg arready_q;
  reg bvalid_q;
  reg [1:0] bresp_q;
  reg rvalid_q;
  reg [1:0] rresp_q;
  reg [31:0] rdata_q;
  integer i;

  wire [255:0] flg_w;
  wire [63:0] ev_w;

  genvar g;
  generate
    for (g = 0; g < `BQM_NQ; g = g + 1) begin : g_q // RQ1
      wire [24:0] c = cfg_q[g];
      wire cur = flg_q[4 * g + c[`BQM_CFG_SRC]]; // RQ6 RQ7
      wire prv = flg_p_q[4 * g + c[`BQM_CFG_SRC]];
      bqm_flags u_flags (
        .cnt_i(cnt_q[g]),
        .size_i(c[`BQM_CFG_SIZE]),
        .esz_i(c[`BQM_CFG_ESZ]),
        .newm_i(c[`BQM_CFG_NEWM]),
        .nfwm_i(c[`BQM_CFG_NFWM]),
        .flag_o(flg_w[4 * g + 3:4 * g])
      );
      // one-cycle event on the chosen edge, gated by the queue's enable
      assign ev_w[g] = c[`BQM_CFG_IEN] & (c[`BQM_CFG_SENSE] ? (prv & ~cur) : (cur & ~prv)); // RQ15 RQ16
    end
  endgenerate

  // write side
  wire wr_go = awready_q & AWVALID_I & WVALID_I;
  wire [2:0] wreg = region(AWADDR_I);
  wire [5:0] wq = AWADDR_I[7:2];
  wire [24:0] wcfg = cfg_q[wq];
  wire [10:0] waddr = wcfg[`BQM_CFG_BASE] + {4'h0, wptr_q[wq]}; // RQ22
  wire [10:0] sram_wa = AWADDR_I[12:2];
  wire [31:0] sram_old = mem_q[sram_wa];
  wire [31:0] sram_new = {WSTRB_I[3] ? WDATA_I[31:24] : sram_old[31:24],
                          WSTRB_I[2] ? WDATA_I[23:16] : sram_old[23:16],
                          WSTRB_I[1] ? WDATA_I[15:8] : sram_old[15:8],
                          WSTRB_I[0] ? WDATA_I[7:0] : sram_old[7:0]};
  // upper queues keep hardware watermarks and the nearly-empty source
  wire [24:0] cfg_new = wq[5] ? {WDATA_I[24:23], `BQM_SRC_NE, `BQM_UP_NFWM,
                                 `BQM_UP_NEWM, WDATA_I[14:0]}
                              : WDATA_I[24:0]; // RQ14 RQ7
  // only one of the two channels is opened per cycle, so no queue is
  // touched by a push and a pop at the same edge
  wire wr_raise = ~awready_q & ~arready_q & ~bvalid_q & AWVALID_I & WVALID_I;

  // read side
  wire rd_go = arready_q & ARVALID_I;
  wire [2:0] rreg = region(ARADDR_I);
  wire [5:0] rq = ARADDR_I[7:2];
  wire [24:0] rcfg = cfg_q[rq];
  wire [10:0] raddr = rcfg[`BQM_CFG_BASE] + {4'h0, rptr_q[rq]}; // RQ22
  wire [3:0] rfl = flg_w[{rq, 2'h0} +: 4];
  wire [5:0] st_lo = {ovf_q[rq], unf_q[rq], rfl[`BQM_FL_F], rfl[`BQM_FL_NF],
                      rfl[`BQM_FL_E], rfl[`BQM_FL_NE]}; // RQ8
  wire [5:0] st_hi = {3'h0, rfl[`BQM_FL_F], 1'b0, rfl[`BQM_FL_NE]}; // RQ9
  wire rd_raise = ~arready_q & ~awready_q & ~rvalid_q & ARVALID_I & ~wr_raise;

  always @(posedge CLK_I) begin
    if (RST_I) begin
      awready_q <= 1'b0;
      arready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `BQM_RESP_OK;
      rvalid_q <= 1'b0;
      rresp_q <= `BQM_RESP_OK;
      rdata_q <= 32'h00000000;
      unf_q <= 64'h0000000000000000;
      ovf_q <= 64'h0000000000000000;
      for (i = 0; i < `BQM_NQ; i = i + 1) begin
        // upper queues leave reset already holding their fixed fields
        cfg_q[i] <= (i < 32) ? `BQM_CFG_RST : `BQM_CFG_UP_RST; // RQ14 RQ7
        wptr_q[i] <= 7'h00;
        rptr_q[i] <= 7'h00;
        wsub_q[i] <= 2'h0;
        rsub_q[i] <= 2'h0;
        cnt_q[i] <= 8'h00;
      end
    end else begin
      awready_q <= wr_raise;
      arready_q <= rd_raise;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wreg == R_NONE) ? `BQM_RESP_SLVERR : `BQM_RESP_OK;
      end else if (bvalid_q && BREADY_I) begin
        bvalid_q <= 1'b0;
      end
      if (wr_go) begin // RQ5
        case (wreg)
          R_QDATA: begin
            if (wsub_q[wq] == 2'h0 && flg_w[{wq, 2'h3}]) begin
              ovf_q[wq] <= 1'b1; // RQ21
            end else begin
              mem_q[waddr] <= WDATA_I; // RQ2
              wptr_q[wq] <= (wptr_q[wq] + 7'h01) & ptr_mask(wcfg[`BQM_CFG_SIZE]); // RQ22
              if (wsub_q[wq] == last_sub(wcfg[`BQM_CFG_ESZ])) begin
                wsub_q[wq] <= 2'h0;
                cnt_q[wq] <= cnt_q[wq] + 8'h01; // RQ11
              end else begin
                wsub_q[wq] <= wsub_q[wq] + 2'h1;
              end
            end
          end
          R_QCFG: begin
            // reconfiguring a queue empties it
            cfg_q[wq] <= cfg_new;
            wptr_q[wq] <= 7'h00;
            rptr_q[wq] <= 7'h00;
            wsub_q[wq] <= 2'h0;
            rsub_q[wq] <= 2'h0;
            cnt_q[wq] <= 8'h00;
            unf_q[wq] <= 1'b0;
            ovf_q[wq] <= 1'b0;
          end
          R_QSTAT: begin
            // pops and pushes never share this edge, so no set is lost
            if (WDATA_I[4])
              unf_q[wq] <= 1'b0;
            if (WDATA_I[5])
              ovf_q[wq] <= 1'b0;
          end
          R_SRAM: begin
            mem_q[sram_wa] <= sram_new;
          end
          default: begin
          end
        endcase
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q <= (rreg == R_NONE) ? `BQM_RESP_SLVERR : `BQM_RESP_OK;
        rdata_q <= 32'h00000000;
        case (rreg)
          R_QDATA: begin
            if (rsub_q[rq] == 2'h0 && flg_w[{rq, 2'h0}]) begin
              unf_q[rq] <= 1'b1; // RQ21
            end else begin
              rdata_q <= mem_q[raddr];
              rptr_q[rq] <= (rptr_q[rq] + 7'h01) & ptr_mask(rcfg[`BQM_CFG_SIZE]); // RQ22
              if (rsub_q[rq] == last_sub(rcfg[`BQM_CFG_ESZ])) begin
                rsub_q[rq] <= 2'h0;
                cnt_q[rq] <= cnt_q[rq] - 8'h01; // RQ11
              end else begin
                rsub_q[rq] <= rsub_q[rq] + 2'h1;
              end
            end
          end
          R_QCFG: rdata_q <= {7'h00, rcfg};
          R_QSTAT: rdata_q <= {16'h0000, cnt_q[rq], 2'h0, rq[5] ? st_hi : st_lo}; // RQ17
          R_ILO: rdata_q <= ist_lo_q;
          R_IHI: rdata_q <= ist_hi_q;
          R_SRAM: rdata_q <= mem_q[ARADDR_I[12:2]];
          default: rdata_q <= 32'h00000000;
        endcase
      end else if (rvalid_q && RREADY_I) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // write-one-to-clear group status; a new event in the same cycle wins
  wire [31:0] ilo_clr = (wr_go && wreg == R_ILO) ? WDATA_I : 32'h00000000;
  wire [31:0] ihi_clr = (wr_go && wreg == R_IHI) ? WDATA_I : 32'h00000000;

  always @(posedge CLK_I) begin
    if (RST_I) begin
      flg_q <= {64{4'h3}};
      flg_p_q <= {64{4'h3}};
      ist_lo_q <= 32'h00000000;
      ist_hi_q <= 32'h00000000;
      irq_lo_q <= 1'b0;
      irq_hi_q <= 1'b0;
    end else begin
      flg_q <= flg_w;
      flg_p_q <= flg_q;
      ist_lo_q <= (ist_lo_q & ~ilo_clr) | ev_w[31:0]; // RQ15
      ist_hi_q <= (ist_hi_q & ~ihi_clr) | ev_w[63:32]; // RQ15
      // falls only when every pending bit of the group is gone
      irq_lo_q <= |ist_lo_q; // RQ4 RQ19
      irq_hi_q <= |ist_hi_q; // RQ4 RQ19
    end
  end

  assign FLAG_BUS_O = flg_q[127:0]; // RQ3
  assign LOWER_GROUP_IRQ_O = irq_lo_q;
  assign UPPER_GROUP_IRQ_O = irq_hi_q;
  assign AWREADY_O = awready_q;
  assign WREADY_O = awready_q;
  assign BVALID_O = bvalid_q;
  assign BRESP_O = bresp_q;
  assign ARREADY_O = arready_q;
  assign RVALID_O = rvalid_q;
  assign RRESP_O = rresp_q;
  assign RDATA_O = rdata_q;
endmodule // bqm_top

// ---- pkg/bqm_map.vh ----
// Function
// RQ1 - sixty-four queues, numbered 0 to 63
// RQ2 - circular queues in one shared 8-Kbyte SRAM
// RQ3 - flags of queues 0-31 driven on flag bus
// RQ4 - lower and upper group interrupt outputs
// RQ5 - bus gives config, entries, status, interrupts, SRAM
// RQ6 - lower queues select source flag and edge
// RQ7 - upper queues notify on nearly-empty only
// RQ8 - lower queues report six status flags
// RQ9 - upper queues report nearly-empty and full only
// RQ10 - queue size 16, 32, 64 or 128 words
// RQ11 - entry size 1, 2 or 4 words
// RQ12 - nearly-empty when occupied at or below watermark
// RQ13 - nearly-full when free at or below watermark
// RQ14 - upper queue watermarks fixed by hardware
// RQ15 - enabled source-flag change raises group interrupt
// RQ16 - per-queue interrupt enable in queue config
// RQ17 - per-queue status shows fullness and entry count
// RQ18 - host keeps all queue regions inside the SRAM
// RQ19 - group interrupt drops once all its flags clear
// RQ20 - host reads status then writes it back to clear
// RQ21 - empty read underflows, full write discarded and overflows
// RQ22 - per-queue base, pointers wrap modulo queue size
`ifndef BQM_MAP_VH
`define BQM_MAP_VH
`define BQM_NQ 64
`define BQM_AW 14
`define BQM_OFF_QDATA 14'h0000
`define BQM_OFF_QCFG 14'h0400
`define BQM_OFF_QSTAT 14'h0500
`define BQM_OFF_ILO 14'h0600
`define BQM_OFF_IHI 14'h0604
`define BQM_OFF_SRAM 14'h2000
`define BQM_CFG_BASE 10:0
`define BQM_CFG_SIZE 12:11
`define BQM_CFG_ESZ 14:13
`define BQM_CFG_NEWM 17:15
`define BQM_CFG_NFWM 20:18
`define BQM_CFG_SRC 22:21
`define BQM_CFG_SENSE 23
`define BQM_CFG_IEN 24
`define BQM_CFG_RST 25'h0000000
`define BQM_CFG_UP_RST 25'h0248000
`define BQM_UP_NEWM 3'h1
`define BQM_UP_NFWM 3'h1
`define BQM_FL_E 0
`define BQM_FL_NE 1
`define BQM_FL_NF 2
`define BQM_FL_F 3
`define BQM_SRC_NE 2'h1
`define BQM_RESP_OK 2'h0
`define BQM_RESP_SLVERR 2'h2
`endif

// ---- rtl/bqm_flags.v ----
`timescale 1ns/10ps
`include "bqm_map.vh"
module bqm_flags (
  input wire [7:0] cnt_i,
  input wire [1:0] size_i,
  input wire [1:0] esz_i,
  input wire [2:0] newm_i,
  input wire [2:0] nfwm_i,
  output wire [3:0] flag_o
);
  function [7:0] wm_dec;
    input [2:0] c;
    begin
      wm_dec = (c == 3'h0) ? 8'h00 : (8'h01 << (c - 3'h1));
    end
  endfunction

  wire [7:0] size_words = 8'h10 << size_i; // RQ10
  // code 3 is not a legal entry size, treated as four words
  wire [1:0] esz_shift = (esz_i == 2'h3) ? 2'h2 : esz_i; // RQ11
  wire [7:0] entries = size_words >> esz_shift; // RQ10
  wire [7:0] free = entries - cnt_i;

  assign flag_o[`BQM_FL_E] = (cnt_i == 8'h00);
  assign flag_o[`BQM_FL_NE] = (cnt_i <= wm_dec(newm_i)); // RQ12
  assign flag_o[`BQM_FL_NF] = (free <= wm_dec(nfwm_i)); // RQ13
  assign flag_o[`BQM_FL_F] = (cnt_i >= entries);
endmodule // bqm_flags

// ---- test/bqm_top_monitor.sv ----
`timescale 1ns/10ps
`include "bqm_map.vh"
module bqm_top_monitor (
  input wire CLK_I,
  input wire RST_I,
  input wire AWVALID_I,
  input wire WVALID_I,
  input wire AWREADY_O,
  input wire WREADY_O,
  input wire BVALID_O,
  input wire BREADY_I,
  input wire ARREADY_O,
  input wire RVALID_O,
  input wire RREADY_I,
  input wire [31:0] RDATA_O,
  input wire [127:0] FLAG_BUS_O
);
  default clocking mon_cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  a_write_pair: assert property (
    AWREADY_O |-> WREADY_O && AWVALID_I && WVALID_I) else $error("write taken apart");
  a_bresp_next: assert property (
    AWREADY_O |=> BVALID_O) else $error("no write answer");
  a_bvalid_hold: assert property (
    BVALID_O && !BREADY_I |=> BVALID_O) else $error("bvalid dropped");
  a_read_answer: assert property (
    ARREADY_O |=> RVALID_O) else $error("no read answer");
  a_rdata_hold: assert property (
    RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O)) else $error("rdata moved");
  a_write_gap: assert property (
    AWREADY_O |=> !AWREADY_O && !ARREADY_O ##1 !AWREADY_O) else $error("write ready too soon");
  a_empty_flags: assert property (
    FLAG_BUS_O[0] |-> FLAG_BUS_O[1] && !FLAG_BUS_O[3]) else $error("empty flags wrong");
  a_full_flags: assert property (
    FLAG_BUS_O[3] |-> FLAG_BUS_O[2]) else $error("full without nearly full");
endmodule // bqm_top_monitor
bind bqm_top bqm_top_monitor mon (.CLK_I(CLK_I), .RST_I(RST_I), .AWVALID_I(AWVALID_I),
  .WVALID_I(WVALID_I), .AWREADY_O(AWREADY_O), .WREADY_O(WREADY_O), .BVALID_O(BVALID_O),
  .BREADY_I(BREADY_I), .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
  .RDATA_O(RDATA_O), .FLAG_BUS_O(FLAG_BUS_O));

// ---- test/bqm_coproc.sv ----
`timescale 1ns/10ps
module bqm_coproc (
  input wire clk_i,
  input wire [127:0] flag_bus_i,
  output reg [31:0] empty_o
);
  integer q;
  // coprocessor only samples; it never drives back into the queue block
  always @(posedge clk_i) begin
    for (q = 0; q < 32; q = q + 1) begin
      empty_o[q] <= flag_bus_i[4*q];
    end
  end
endmodule // bqm_coproc

// ---- test/hardware_queue_manager_bench.sv ----
`timescale 1ns/10ps
`include "bqm_map.vh"
module hardware_queue_manager_bench;
  reg clk = 0;
  reg rst = 1;
  reg [13:0] awaddr = 0;
  reg [13:0] araddr = 0;
  reg [31:0] wdata = 0;
  reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire awready, wready, bvalid, arready, rvalid, lirq, uirq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, cp_empty;
  wire [127:0] flags;
  reg [33:0] expq[$];
  reg [31:0] dat[0:15];
  integer n_errors = 0, comparisons = 0, seed = 70, i, cyc = 0;
  bqm_top dut (.CLK_I(clk), .RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid),
    .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .FLAG_BUS_O(flags),
    .LOWER_GROUP_IRQ_O(lirq), .UPPER_GROUP_IRQ_O(uirq));
  bqm_coproc cop (.clk_i(clk), .flag_bus_i(flags), .empty_o(cp_empty));
  initial forever #50 clk = ~clk;
  task chk(input string nm, input [33:0] exp, input [33:0] seen);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(input [13:0] a, input [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // ready seen at the falling edge is what the next rising edge samples
    do @(negedge clk); while (!awready);
    @(posedge clk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(negedge clk); while (!bvalid);
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task rd(input [13:0] a, input [33:0] e);
    @(posedge clk);
    expq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    @(posedge clk);
    rready <= 1'b0;
  endtask
  always @(negedge clk) begin
    if (rvalid && rready) chk("read", expq.pop_front(), {rresp, rdata});
    if (bvalid && bready) chk("bresp", 34'h0, {32'h0, bresp});
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(14'h0400, 34'h0);
    rd(14'h0500, 34'h3);
    rd(14'h05A0, 34'h1);
    rd(14'h04A0, 34'h000248000);
    rd(14'h0700, 34'h200000000);
    wr(14'h0400, 32'h01A50010);
    for (i = 0; i < 16; i = i + 1) begin
      dat[i] = $random(seed);
      wr(14'h0000, dat[i]);
      if (i == 1) rd(14'h0500, 34'h201);
      if (i == 14) rd(14'h0500, 34'hF04);
    end
    rd(14'h0500, 34'h100C);
    @(negedge clk);
    chk("flag_bus", 34'hC, {30'h0, flags[3:0]});
    chk("lower_irq", 34'h1, {33'h0, lirq});
    chk("upper_irq", 34'h0, {33'h0, uirq});
    rd(14'h0600, 34'h1);
    wr(14'h0600, 32'h1);
    wr(14'h0000, $random(seed));
    rd(14'h0500, 34'h102C);
    rd(14'h2040, {2'h0, dat[0]});
    @(negedge clk);
    chk("lower_irq", 34'h0, {33'h0, lirq});
    for (i = 0; i < 16; i = i + 1) rd(14'h0000, {2'h0, dat[i]});
    rd(14'h0000, 34'h0);
    rd(14'h0500, 34'h33);
    @(negedge clk);
    chk("coproc", 34'h3, {32'h0, cp_empty[1:0]});
    wr(14'h0404, 32'h00002040);
    wr(14'h0004, $random(seed));
    rd(14'h0504, 34'h3);
    wr(14'h0004, $random(seed));
    rd(14'h0504, 34'h100);
    wr(14'h0480, 32'h01800100);
    wr(14'h0080, $random(seed));
    wr(14'h0080, $random(seed));
    rd(14'h0580, 34'h200);
    rd(14'h0604, 34'h1);
    @(negedge clk);
    chk("upper_irq", 34'h1, {33'h0, uirq});
    report_and_stop;
  end
endmodule // hardware_queue_manager_bench
